// ### src/vfi_consts.vh
`ifndef VFI_CONSTS_VH
`define VFI_CONSTS_VH
// ==========================================
// register map (word addresses, byte = 4x)
`define VFI_ADDR_W 4
`define VFI_REG_STD 4'h0
`define VFI_REG_CTRL 4'h1
`define VFI_REG_CAP 4'h2
// ==========================================
// status register fields
`define VFI_STD_LSB 0
`define VFI_STD_MSB 4
`define VFI_LUMA_LSB 8
`define VFI_LUMA_MSB 11
`define VFI_CHROMA_LSB 12
`define VFI_CHROMA_MSB 15
`define VFI_RATE_BIT 16
`define VFI_LOCK_BIT 17
`define VFI_THRU_BIT 18
// ==========================================
// control register fields
`define VFI_CTRL_THRU_BIT 0
`define VFI_CTRL_RST 32'h0000_0000
// ==========================================
// format codes
`define VFI_FMT_SDTI_FIXED 4'h4
`define VFI_FMT_SDTI_VAR 4'h5
`define VFI_FMT_SDI 4'h6
`define VFI_FMT_ASI 4'h7
`define VFI_FMT_TDM 4'h8
`define VFI_FMT_RSV_LO 4'h9
`define VFI_FMT_RSV_HI 4'he
`define VFI_FMT_UNKNOWN 4'hf
// ==========================================
// standard codes
`define VFI_STD_720_25_EM 5'h07
`define VFI_STD_720_24 5'h08
`define VFI_STD_720_24_EM 5'h09
`define VFI_STD_1080_FIRST 5'h0a
`define VFI_STD_1080_LAST 5'h13
`define VFI_STD_1080_295 5'h14
`define VFI_STD_1035 5'h15
`define VFI_STD_525_487 5'h16
`define VFI_STD_525_507 5'h17
`define VFI_STD_625 5'h18
`define VFI_STD_525_487_GEN 5'h19
`define VFI_STD_625_GEN 5'h1a
`define VFI_STD_525_507_GEN 5'h1b
`define VFI_STD_RSV_A 5'h1c
`define VFI_STD_UNK_HD 5'h1d
`define VFI_STD_UNK_SD 5'h1e
`define VFI_STD_RSV_B 5'h1f
`endif

// ### src/vfi_fmt_field.v
`include "vfi_consts.vh"
// ==========================================
// one 4-bit format field holding register
module vfi_fmt_field (
   input wire clock, // core clock
   input wire rst, // sync reset, high
   input wire ce, // clock enable
   input wire clear, // force unknown
   input wire load, // take new code
   input wire [3:0] code_in, // offered code
   output reg [3:0] code_q // held code
);
   // reserved codes are kept but read as unknown to the host
   always @(posedge clock)
   begin
      if (rst)
         code_q <= `VFI_FMT_UNKNOWN;
      else if (ce)
      begin
         if (clear)
            code_q <= `VFI_FMT_UNKNOWN;
         else if (load)
            code_q <= code_in;
      end
   end
endmodule // vfi_fmt_field

// ### src/vfi_top.v
// Register access over Avalon-MM and the placing of the registers were decided locally.
`include "vfi_consts.vh"

module vfi_top (
   input wire clock, // core clock, 250 mhz
   input wire rst, // sync reset, high
   input wire ce, // clock enable
   input wire rate_select, // low = hd, high = sd/asi
   input wire locked, // receiver locked
   input wire std_valid, // detector offers new code, pulse
   input wire [4:0] std_in, // detected standard code
   input wire fmt_valid, // payload id offers codes, pulse
   input wire [3:0] luma_in, // offered luma format
   input wire [3:0] chroma_in, // offered chroma format
   input wire [`VFI_ADDR_W-1:0] avs_address, // word address
   input wire avs_read, // read request
   input wire avs_write, // write request
   input wire [31:0] avs_writedata, // write data
   input wire [3:0] avs_byteenable, // byte lanes
   output wire avs_waitrequest, // stall
   output reg [31:0] avs_readdata, // read data
   output reg [1:0] avs_response, // 00 ok, 10 slave error
   output reg [4:0] standard_code, // held standard code
   output wire [3:0] luma_format_code, // luma format field
   output wire [3:0] chroma_format_code, // chroma format field
   output wire data_through // data-through mode active
);
   // ==========================================
   // standard code validation
   reg [4:0] std_q;
   reg [4:0] std_d;
   reg std_ok;
   always @*
   begin
      std_ok = 1'b1;
      case (std_in)
         // 720-line codes pass at either rate
         `VFI_STD_720_25_EM: std_ok = 1'b1;
         `VFI_STD_720_24: std_ok = 1'b1;
         `VFI_STD_720_24_EM: std_ok = 1'b1;
         // the 295m and 1035-line formats exist at the hd rate only
         `VFI_STD_1080_295: std_ok = ~rate_select;
         `VFI_STD_1035: std_ok = ~rate_select;
         // sd codes only make sense at the sd rate
         `VFI_STD_525_487: std_ok = rate_select;
         `VFI_STD_525_507: std_ok = rate_select;
         `VFI_STD_625: std_ok = rate_select;
         `VFI_STD_525_487_GEN: std_ok = rate_select;
         `VFI_STD_625_GEN: std_ok = rate_select;
         `VFI_STD_525_507_GEN: std_ok = rate_select;
         // reserved codes are never stored as offered
         `VFI_STD_RSV_A: std_ok = 1'b0;
         `VFI_STD_RSV_B: std_ok = 1'b0;
         // 1080-line and remaining codes pass as offered
         default: std_ok = 1'b1;
      endcase
      // reserved or mismatched rate falls back to the unknown code
      if (std_ok)
         std_d = std_in;
      else if (rate_select)
         std_d = `VFI_STD_UNK_SD;
      else
         std_d = `VFI_STD_UNK_HD;
   end

   // ==========================================
   // control register, data-through enable
   // only bit 0 is stored; the upper bits read back as zero
   // data-through is a plain level, so the fields clear at the next enabled edge
   reg [31:0] ctrl_q;
   assign data_through = ctrl_q[`VFI_CTRL_THRU_BIT];

   // ==========================================
   // format field clearing and steering
   wire fmt_clear;
   wire [3:0] luma_d;
   wire [3:0] chroma_d;
   wire [3:0] luma_raw;
   wire [3:0] chroma_raw;
   assign fmt_clear = ~locked | data_through;
   assign luma_d = luma_in;
   // sd and asi only carry one payload, chroma is meaningless
   assign chroma_d = rate_select ? `VFI_FMT_UNKNOWN : chroma_in;
   // chroma also sits at unknown for as long as the sd rate is selected
   wire chroma_clear;
   assign chroma_clear = fmt_clear | rate_select;

   // luma field loads at both rates, but not while unlocked or in data-through
   vfi_fmt_field u_luma (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .clear(fmt_clear),
      .load(fmt_valid),
      .code_in(luma_d),
      .code_q(luma_raw)
   );

   // chroma field only keeps what the hd rate lets through
   vfi_fmt_field u_chroma (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .clear(chroma_clear),
      .load(fmt_valid),
      .code_in(chroma_d),
      .code_q(chroma_raw)
   );

   // reserved codes 9h..eh are shown as unknown
   function [3:0] vfi_fmt_show;
      input [3:0] c;
      begin
         if (c >= `VFI_FMT_RSV_LO && c <= `VFI_FMT_RSV_HI)
            vfi_fmt_show = `VFI_FMT_UNKNOWN;
         else
            vfi_fmt_show = c;
      end
   endfunction
   // mapping sits after the register, so a reserved load costs no state
   assign luma_format_code = vfi_fmt_show(luma_raw);
   assign chroma_format_code = vfi_fmt_show(chroma_raw);

   // ==========================================
   // standard code register; unknown when not locked
   always @(posedge clock)
   begin
      if (rst)
      begin
         std_q <= `VFI_STD_UNK_HD;
      end
      else if (ce)
      begin
         // a clear beats a load landing in the same cycle
         if (fmt_clear)
            std_q <= rate_select ? `VFI_STD_UNK_SD : `VFI_STD_UNK_HD;
         else if (std_valid)
            std_q <= std_d;
      end
   end
   // mirror the held code onto its port
   always @*
   begin
      standard_code = std_q;
   end

   // ==========================================
   // avalon slave: one wait state per access, then answer
   // the request is taken at the first edge it is seen and the answer is
   // registered there; costs one stall per access but keeps the address
   // decoder out of the readdata path
   reg ack_q;
   wire req;
   reg [31:0] rd_d;
   reg [1:0] resp_d;
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_q;
   // only the low byte lane carries a control bit
   wire ctrl_we;
   assign ctrl_we = avs_write & (avs_address == `VFI_REG_CTRL)
      & avs_byteenable[0];

   always @*
   begin
      rd_d = 32'h0000_0000;
      resp_d = 2'h0;
      case (avs_address)
         // status word: codes plus the three live mode bits
         `VFI_REG_STD:
         begin
            rd_d[`VFI_STD_MSB:`VFI_STD_LSB] = std_q;
            rd_d[`VFI_LUMA_MSB:`VFI_LUMA_LSB] = luma_format_code;
            rd_d[`VFI_CHROMA_MSB:`VFI_CHROMA_LSB] = chroma_format_code;
            rd_d[`VFI_RATE_BIT] = rate_select;
            rd_d[`VFI_LOCK_BIT] = locked;
            rd_d[`VFI_THRU_BIT] = data_through;
         end
         `VFI_REG_CTRL: rd_d = ctrl_q;
         // capability word reads zero, kept free for later use
         `VFI_REG_CAP: rd_d = 32'h0000_0000;
         // any other word answers with a slave error
         default: resp_d = 2'h2;
      endcase
   end

   // status word ignores writes; only the control word stores
   always @(posedge clock)
   begin
      if (rst)
      begin
         // bus idle, data-through off
         ack_q <= 1'b0;
         ctrl_q <= `VFI_CTRL_RST;
         avs_readdata <= 32'h0000_0000;
         avs_response <= 2'h0;
      end
      else if (ce)
      begin
         // one-cycle acknowledge, so a held request is not taken twice
         ack_q <= req & ~ack_q;
         if (req & ~ack_q)
         begin
            avs_readdata <= avs_read ? rd_d : 32'h0000_0000;
            avs_response <= resp_d;
            if (ctrl_we)
               ctrl_q[`VFI_CTRL_THRU_BIT] <=
                  avs_writedata[`VFI_CTRL_THRU_BIT];
            // writes to the status word are dropped
         end
      end
   end

endmodule // vfi_top

// ### verif/vfi_checker.sv
// ==========================================
// format field and bus checks
module vfi_checker (
   input logic clock, // clk
   input logic rst, // sync rst
   input logic ce, // enable
   input logic rate_select, // sd
   input logic locked, // lock
   input logic fmt_valid, // load
   input logic [3:0] luma_in, // offered
   input logic [3:0] chroma_in, // offered
   input logic [3:0] avs_address, // bus
   input logic avs_read, // bus
   input logic avs_write, // bus
   input logic avs_waitrequest, // bus
   input logic [1:0] avs_response, // bus
   input logic [3:0] luma_format_code, // field
   input logic [3:0] chroma_format_code, // field
   input logic data_through // mode
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   AST_HD_LOAD: assert property (ce && fmt_valid && !rate_select
      && locked && !data_through && luma_in < 4'h9 && chroma_in < 4'h9
      |=> luma_format_code == $past(luma_in)
      && chroma_format_code == $past(chroma_in)) else $error("hd load");
   AST_SD_CHROMA: assert property (ce && fmt_valid && rate_select
      |=> chroma_format_code == 4'hf) else $error("sd chroma");
   AST_RESET_UNK: assert property ($past(rst)
      |-> luma_format_code == 4'hf && chroma_format_code == 4'hf)
      else $error("reset value");
   AST_LOCK_UNK: assert property (ce && !locked
      |=> luma_format_code == 4'hf && chroma_format_code == 4'hf)
      else $error("lock loss");
   AST_THRU_UNK: assert property (ce && data_through
      |=> luma_format_code == 4'hf) else $error("data through");
   AST_RSV_MAP: assert property (!(luma_format_code inside
      {[4'h9:4'he]})) else $error("reserved code shown");
   // with the clock enable high, the bus answers after exactly one wait state
   AST_ONE_WAIT: assert property ((avs_read || avs_write) && ce
      && avs_waitrequest |=> !avs_waitrequest) else $error("wait");
   AST_UNMAPPED: assert property ((avs_read || avs_write)
      && !avs_waitrequest && avs_address > 4'h2
      |-> avs_response == 2'h2) else $error("unmapped");
endmodule // vfi_checker
bind vfi_top vfi_checker u_chk (.*);

// ### verif/video_format_indication_tb.sv
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
// ==========================================
// bench top
module video_format_indication_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, rst = 1, ce = 1, rate_select = 0, locked = 1;
   logic std_valid = 0, fmt_valid = 0, avs_read = 0, avs_write = 0;
   logic [4:0] std_in = 0;
   logic [3:0] luma_in = 0, chroma_in = 0, avs_address = 0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_writedata = 0, rdata;
   logic [1:0] rsp;
   logic [4:0] es;
   wire avs_waitrequest, data_through;
   wire [31:0] avs_readdata;
   wire [1:0] avs_response;
   wire [4:0] standard_code;
   wire [3:0] luma_format_code, chroma_format_code;
   int bad_count = 0, checked = 0;
   vfi_top u_dut (.*);
   // free-running core clock
   always #2 clock = ~clock;
   // one bus access, held until waitrequest is seen low
   task acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
      logic w;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      w = 1'b1;
      // look at the settled outputs mid-cycle; leave on the edge after
      while (w)
      begin
         @(negedge clock);
         w = avs_waitrequest;
         rdata = avs_readdata;
         rsp = avs_response;
         @(posedge clock);
      end
      avs_write <= 0;
      avs_read <= 0;
   endtask
   // offer standard and format codes for one cycle
   task ld(input logic [4:0] s, input logic [3:0] l, c);
      @(posedge clock);
      {std_valid, fmt_valid, std_in, luma_in, chroma_in} <= {2'h3, s, l, c};
      @(posedge clock);
      {std_valid, fmt_valid} <= 2'h0;
      #1;
   endtask
   task end_sim;
      if (bad_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // watchdog: far beyond the hundred or so cycles needed
   initial
   begin
      repeat (5000) @(posedge clock);
      bad_count++;
      end_sim;
   end
   // main sequence
   initial
   begin
      repeat (5) @(posedge clock);
      rst <= 0;
      acc(0, 4'h0, 0);
      `CHK("status", 32'h0002_ff1d, rdata)
      ld(5'h0a, 4'h6, 4'h3);
      `CHK("chroma", 4'h3, chroma_format_code)
      for (int i = 0; i < 16; i++)
      begin
         ld(5'h07 + 5'(i), 4'(i), 4'h2);
         `CHK("luma", (i > 8) ? 4'hf : 4'(i), luma_format_code)
         es = (i < 15) ? 5'h07 + 5'(i) : 5'h1d;
         `CHK("std", es, standard_code)
      end
      acc(1, 4'h0, 0);
      acc(0, 4'h0, 0);
      `CHK("ro", 32'h0002_2f1d, rdata)
      acc(0, 4'h3, 0);
      `CHK("rsp", 2'h2, rsp)
      @(posedge clock);
      rate_select <= 1;
      for (int i = 0; i < 7; i++)
      begin
         ld(5'h16 + 5'(i), 4'h7, 4'h2);
         `CHK("sd", 8'hf7, {chroma_format_code, luma_format_code})
         `CHK("std", (i < 6) ? 5'h16 + 5'(i) : 5'h1e, standard_code)
      end
      acc(1, 4'h1, 1);
      @(posedge clock);
      #1;
      `CHK("thru", 5'h1f, {data_through, luma_format_code})
      acc(0, 4'h1, 0);
      `CHK("ctrl", 32'h0000_0001, rdata)
      acc(1, 4'h1, 0);
      ld(5'h16, 4'h6, 4'h2);
      @(posedge clock);
      locked <= 0;
      @(posedge clock);
      #1;
      `CHK("lock", 9'h1ef, {standard_code, luma_format_code})
      // clock enable low: relock and a load must leave everything frozen
      @(posedge clock);
      ce <= 0;
      locked <= 1;
      ld(5'h18, 4'h3, 4'h2);
      `CHK("frozen", 9'h1ef, {standard_code, luma_format_code})
      @(posedge clock);
      ce <= 1;
      ld(5'h18, 4'h3, 4'h2);
      `CHK("relock", 9'h183, {standard_code, luma_format_code})
      // second reset in mid-run
      @(posedge clock);
      rst <= 1;
      repeat (2) @(posedge clock);
      rst <= 0;
      acc(0, 4'h0, 0);
      `CHK("rst2", 32'h0003_ff1d, rdata)
      end_sim;
   end
endmodule // video_format_indication_tb
